// file: rtl/prc_map.vh
// Purpose: constants for the pll reconfiguration controller
// Assumes: byte addresses on a 32-bit avalon-mm slave
// Notes:   every offset, control and interrupt field and count lives here, and each image reset value but the post phase one
`ifndef PRC_MAP_VH
`define PRC_MAP_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define PRC_CLK_MHZ 50
`define PRC_LOCK_NS 10000
`define PRC_LOCK_CYC ((`PRC_LOCK_NS * `PRC_CLK_MHZ + 999) / 1000)
`define PRC_SCAN_BITS 144
`define PRC_PHASE_CYC 4

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PRC_OFS_CTRL 8'h00
`define PRC_OFS_STATUS 8'h04
`define PRC_OFS_ISTAT 8'h08
`define PRC_OFS_IMASK 8'h0C
`define PRC_OFS_SLOOP 8'h10
`define PRC_OFS_ALOOP 8'h14
`define PRC_OFS_ELOOP 8'h18
`define PRC_OFS_PHASE 8'h1C
`define PRC_OFS_SPOST 8'h20
`define PRC_OFS_APOST 8'h40
`define PRC_NUM_POST 5

// ----------------------------------------
// control fields
// ----------------------------------------
`define PRC_CTRL_START 0
`define PRC_CTRL_ARST 1
`define PRC_CTRL_STEP 2
`define PRC_CTRL_DIR 3
`define PRC_CTRL_SEL 6:4
`define PRC_SEL_M 3'h5
`define PRC_SEL_ALL 3'h6

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define PRC_IRQ_SCAN 0
`define PRC_IRQ_PHASE 1
`define PRC_IRQ_LOST 2
`define PRC_IRQ_GAIN 3
`define PRC_IRQ_W 4

// ----------------------------------------
// settings layout and image values
// ----------------------------------------
`define PRC_LOOP_W 24
`define PRC_IMG_LOOP 24'h01_0101
`define PRC_IMG_POST 8'h01
`define PRC_IMG_MPH 3'h0

`endif

// file: rtl/prc_lock_timer.v
// Purpose: models lock acquisition of the loop as a fixed wait
// Assumes: restart is a one-cycle pulse, hold is a level
// Notes:   lock drops at once on restart or hold
`timescale 1ns/10ps
`include "prc_map.vh"

module prc_lock_timer #(
   parameter LOCK_CYC = `PRC_LOCK_CYC
) (
   input wire clk,          // system clock
   input wire sys_rst,      // sync reset, active high
   input wire restart,      // begin a new acquisition
   input wire hold,         // pll reset level
   output reg locked        // lock indication
);

   reg [15:0] cnt_reg;

   // ----------------------------------------
   // acquisition counter
   // ----------------------------------------
   // counter restarts from zero so a late change gives a full wait
   always @(posedge clk) begin
      if (sys_rst || restart || hold) begin
         cnt_reg <= 16'h0000;
         locked <= 1'b0;
      end else if (!locked) begin
         if (cnt_reg == LOCK_CYC[15:0] - 16'h0001) begin
            locked <= 1'b1;
         end
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

endmodule

// file: rtl/prc_top.v
// Purpose: register-driven pll reconfiguration and phase-step controller
// Assumes: clk doubles as the free-running scan clock
// Notes:   avalon-mm slave, one wait state on every access
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "prc_map.vh"

module prc_top #(
   parameter LOCK_CYC = `PRC_LOCK_CYC
) (
   input wire clk,                 // system and scan clock
   input wire sys_rst,             // sync reset, active high
   input wire [7:0] avm_address,   // byte address
   input wire avm_read,            // read request
   input wire avm_write,           // write request
   input wire [31:0] avm_writedata, // write data
   output reg [31:0] avm_readdata, // read data
   output reg avm_waitrequest,     // stall, low for the answer
   output reg irq,                 // level interrupt
   output wire pll_locked,         // lock indication
   output reg scan_done,           // reconfiguration complete pulse
   output reg recfg_busy,          // reconfiguration in progress
   output reg phase_done           // phase step complete
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   localparam ST_IDLE = 2'd0;
   localparam ST_SHIFT = 2'd1;
   localparam ST_APPLY = 2'd2;

   reg [1:0] state_reg;
   reg [7:0] scan_cnt_reg;
   reg [2:0] ph_cnt_reg;
   reg ph_dir_reg;
   reg [2:0] ph_sel_reg;
   reg arst_reg;
   reg chain_loaded_reg;
   reg [`PRC_LOOP_W-1:0] shd_loop_reg;
   reg [`PRC_LOOP_W-1:0] act_loop_reg;
   reg [`PRC_LOOP_W-1:0] eff_loop_reg;
   reg [7:0] shd_post_reg [0:`PRC_NUM_POST-1];
   reg [7:0] act_post_reg [0:`PRC_NUM_POST-1];
   reg [2:0] ph_post_reg [0:`PRC_NUM_POST-1];
   reg [2:0] ph_m_reg;
   reg [`PRC_IRQ_W-1:0] istat_reg;
   reg [`PRC_IRQ_W-1:0] imask_reg;
   reg [`PRC_IRQ_W-1:0] ev_next;
   reg lock_d_reg;
   reg relock_reg;
   reg [31:0] rdata_next;
   wire wr_go;
   wire req_new;
   wire start_req;
   wire step_req;
   wire lock_rise;
   wire lock_fall;
   integer i;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // one eighth step, wraps through the octant
   function [2:0] prc_step;
      input [2:0] ph;
      input dir;
      begin
         if (dir) begin
            prc_step = ph - 3'h1;
         end else begin
            prc_step = ph + 3'h1;
         end
      end
   endfunction

   // index of a post-scale word at a given base, or 7 when outside
   function [2:0] prc_post_idx;
      input [7:0] addr;
      input [7:0] base;
      reg [7:0] d;
      begin
         d = addr - base;
         if (addr >= base && d[1:0] == 2'b00 && d[7:2] < `PRC_NUM_POST) begin
            prc_post_idx = d[4:2];
         end else begin
            prc_post_idx = 3'h7;
         end
      end
   endfunction

   // ----------------------------------------
   // bus strobes
   // ----------------------------------------
   assign req_new = (avm_read || avm_write) && avm_waitrequest;
   assign wr_go = avm_write && !avm_waitrequest;
   assign start_req = wr_go && avm_address == `PRC_OFS_CTRL && avm_writedata[`PRC_CTRL_START];
   assign step_req = wr_go && avm_address == `PRC_OFS_CTRL && avm_writedata[`PRC_CTRL_STEP];
   assign lock_rise = pll_locked && !lock_d_reg;
   assign lock_fall = !pll_locked && lock_d_reg;

   // ----------------------------------------
   // lock model
   // ----------------------------------------
   prc_lock_timer #(
      .LOCK_CYC(LOCK_CYC)
   ) u_lock (
      .clk(clk),
      .sys_rst(sys_rst),
      .restart(relock_reg),
      .hold(arst_reg),
      .locked(pll_locked)
   );

   // ----------------------------------------
   // avalon handshake and read mux
   // ----------------------------------------
   // a fixed single wait state keeps the read mux off the critical path
   always @(posedge clk) begin
      if (sys_rst) begin
         avm_waitrequest <= 1'b1;
         avm_readdata <= 32'h0000_0000;
      end else begin
         avm_waitrequest <= !req_new;
         if (req_new && avm_read) begin
            avm_readdata <= rdata_next;
         end
      end
   end

   always @* begin
      rdata_next = 32'h0000_0000;
      case (avm_address)
         `PRC_OFS_CTRL: rdata_next = {25'h0, ph_sel_reg, ph_dir_reg, 1'b0, arst_reg, 1'b0};
         `PRC_OFS_STATUS: rdata_next = {28'h0, chain_loaded_reg, phase_done, recfg_busy, pll_locked};
         `PRC_OFS_ISTAT: rdata_next = {28'h0, istat_reg};
         `PRC_OFS_IMASK: rdata_next = {28'h0, imask_reg};
         `PRC_OFS_SLOOP: rdata_next = {8'h00, shd_loop_reg};
         `PRC_OFS_ALOOP: rdata_next = {8'h00, act_loop_reg};
         `PRC_OFS_ELOOP: rdata_next = {8'h00, eff_loop_reg};
         `PRC_OFS_PHASE: rdata_next = {14'h0, ph_m_reg, ph_post_reg[4], ph_post_reg[3],
                                       ph_post_reg[2], ph_post_reg[1], ph_post_reg[0]};
         default: begin
            if (prc_post_idx(avm_address, `PRC_OFS_SPOST) != 3'h7) begin
               rdata_next = {24'h0, shd_post_reg[prc_post_idx(avm_address, `PRC_OFS_SPOST)]};
            end else if (prc_post_idx(avm_address, `PRC_OFS_APOST) != 3'h7) begin
               rdata_next = {24'h0, act_post_reg[prc_post_idx(avm_address, `PRC_OFS_APOST)]};
            end
         end
      endcase
   end

   // ----------------------------------------
   // scan chain shadow
   // ----------------------------------------
   // shadow starts blank; nothing is applied until software fills it
   always @(posedge clk) begin
      if (sys_rst) begin
         shd_loop_reg <= {`PRC_LOOP_W{1'b0}};
         chain_loaded_reg <= 1'b0;
         for (i = 0; i < `PRC_NUM_POST; i = i + 1) begin
            shd_post_reg[i] <= 8'h00;
         end
      end else if (wr_go && state_reg == ST_IDLE) begin
         if (avm_address == `PRC_OFS_SLOOP) begin
            shd_loop_reg <= avm_writedata[`PRC_LOOP_W-1:0];
            chain_loaded_reg <= 1'b1;
         end
         for (i = 0; i < `PRC_NUM_POST; i = i + 1) begin
            if (prc_post_idx(avm_address, `PRC_OFS_SPOST) == i[2:0]) begin
               shd_post_reg[i] <= avm_writedata[7:0];
               chain_loaded_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // reconfiguration sequencer
   // ----------------------------------------
   // the shift runs on the free clock, no gating of the scan clock needed
   always @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         scan_cnt_reg <= 8'h00;
         recfg_busy <= 1'b0;
         scan_done <= 1'b0;
      end else begin
         scan_done <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (start_req && chain_loaded_reg && !recfg_busy) begin
                  state_reg <= ST_SHIFT;
                  recfg_busy <= 1'b1;
                  scan_cnt_reg <= 8'h00;
               end
            end
            ST_SHIFT: begin
               scan_cnt_reg <= scan_cnt_reg + 8'h01;
               if (scan_cnt_reg == `PRC_SCAN_BITS - 1) begin
                  state_reg <= ST_APPLY;
               end
            end
            ST_APPLY: begin
               state_reg <= ST_IDLE;
               recfg_busy <= 1'b0;
               scan_done <= 1'b1;
            end
            default: begin
               state_reg <= ST_IDLE;
               recfg_busy <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // active settings and phase stepping
   // ----------------------------------------
   // loop change restarts lock; post words alone never touch it
   always @(posedge clk) begin
      if (sys_rst) begin
         act_loop_reg <= `PRC_IMG_LOOP;
         ph_m_reg <= `PRC_IMG_MPH;
         relock_reg <= 1'b0;
         ph_cnt_reg <= 3'h0;
         ph_dir_reg <= 1'b0;
         ph_sel_reg <= 3'h0;
         phase_done <= 1'b1;
         for (i = 0; i < `PRC_NUM_POST; i = i + 1) begin
            act_post_reg[i] <= `PRC_IMG_POST;
            ph_post_reg[i] <= 3'h0;
         end
      end else begin
         relock_reg <= 1'b0;
         if (state_reg == ST_APPLY) begin
            act_loop_reg <= shd_loop_reg;
            if (shd_loop_reg != act_loop_reg) begin
               relock_reg <= 1'b1;
            end
            for (i = 0; i < `PRC_NUM_POST; i = i + 1) begin
               act_post_reg[i] <= shd_post_reg[i];
            end
         end
         if (arst_reg) begin
            // pll reset empties the phase accumulators and aborts a step
            ph_m_reg <= 3'h0;
            ph_cnt_reg <= 3'h0;
            phase_done <= 1'b1;
            for (i = 0; i < `PRC_NUM_POST; i = i + 1) begin
               ph_post_reg[i] <= 3'h0;
            end
         end else if (step_req && phase_done) begin
            phase_done <= 1'b0;
            ph_cnt_reg <= 3'h0;
            ph_dir_reg <= avm_writedata[`PRC_CTRL_DIR];
            ph_sel_reg <= avm_writedata[`PRC_CTRL_SEL];
         end else if (!phase_done) begin
            ph_cnt_reg <= ph_cnt_reg + 3'h1;
            if (ph_cnt_reg == `PRC_PHASE_CYC - 1) begin
               phase_done <= 1'b1;
               if (ph_sel_reg == `PRC_SEL_M) begin
                  ph_m_reg <= prc_step(ph_m_reg, ph_dir_reg);
                  relock_reg <= 1'b1;
               end
               for (i = 0; i < `PRC_NUM_POST; i = i + 1) begin
                  if (ph_sel_reg == `PRC_SEL_ALL || ph_sel_reg == i[2:0]) begin
                     ph_post_reg[i] <= prc_step(ph_post_reg[i], ph_dir_reg);
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------
   // effective frequency and pll reset
   // ----------------------------------------
   // a post-only reconfiguration leaves lock high, so eff stays put
   always @(posedge clk) begin
      if (sys_rst) begin
         eff_loop_reg <= `PRC_IMG_LOOP;
         arst_reg <= 1'b0;
         lock_d_reg <= 1'b0;
      end else begin
         lock_d_reg <= pll_locked;
         if (lock_rise) begin
            eff_loop_reg <= act_loop_reg;
         end
         if (wr_go && avm_address == `PRC_OFS_CTRL) begin
            arst_reg <= avm_writedata[`PRC_CTRL_ARST];
         end
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   always @* begin
      ev_next = {`PRC_IRQ_W{1'b0}};
      ev_next[`PRC_IRQ_SCAN] = state_reg == ST_APPLY;
      ev_next[`PRC_IRQ_PHASE] = !phase_done && !arst_reg && ph_cnt_reg == `PRC_PHASE_CYC - 1;
      ev_next[`PRC_IRQ_LOST] = lock_fall;
      ev_next[`PRC_IRQ_GAIN] = lock_rise;
   end

   // set beats a same-cycle write-one clear
   always @(posedge clk) begin
      if (sys_rst) begin
         istat_reg <= {`PRC_IRQ_W{1'b0}};
         imask_reg <= {`PRC_IRQ_W{1'b0}};
         irq <= 1'b0;
      end else begin
         if (wr_go && avm_address == `PRC_OFS_ISTAT) begin
            istat_reg <= (istat_reg & ~avm_writedata[`PRC_IRQ_W-1:0]) | ev_next;
         end else begin
            istat_reg <= istat_reg | ev_next;
         end
         if (wr_go && avm_address == `PRC_OFS_IMASK) begin
            imask_reg <= avm_writedata[`PRC_IRQ_W-1:0];
         end
         irq <= |(istat_reg & imask_reg);
      end
   end

endmodule

// file: verif/prc_checker.sv
// Purpose: port-level checks for prc_top
// Assumes: one clock domain, sync reset
// Notes:   attached by bind after the module
`timescale 1ns/10ps
`include "prc_map.vh"
module prc_checker #(
   parameter LOCK_CYC = 8
) (
   input wire clk,                   // clock
   input wire sys_rst,               // sync reset
   input wire [7:0] avm_address,     // byte address
   input wire avm_read,              // read request
   input wire avm_write,             // write request
   input wire [31:0] avm_writedata,  // write data
   input wire [31:0] avm_readdata,   // read data
   input wire avm_waitrequest,       // stall
   input wire irq,                   // interrupt
   input wire pll_locked,            // lock level
   input wire scan_done,             // completion pulse
   input wire recfg_busy,            // busy level
   input wire phase_done             // step complete
);
   localparam int BUSY_CYC = `PRC_SCAN_BITS + 1;
   int busy_cnt;
   int unlk_cnt;
   wire ctrl_wr = avm_write && !avm_waitrequest && avm_address == `PRC_OFS_CTRL;
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   // cycle counts, so long spans need no big repetition
   always @(posedge clk) begin
      busy_cnt <= (sys_rst || !recfg_busy) ? 0 : busy_cnt + 1;
      unlk_cnt <= (sys_rst || pll_locked) ? 0 : unlk_cnt + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_wait_one_cycle: assert property ((avm_read || avm_write) && avm_waitrequest |=>
      !avm_waitrequest ##1 avm_waitrequest) else $error("bus answer not one cycle");
   a_done_pulse: assert property (scan_done |=> !scan_done)
      else $error("completion pulse too long");
   a_done_ends_busy: assert property (scan_done |-> !recfg_busy && $past(recfg_busy))
      else $error("completion not at end of busy");
   a_busy_length: assert property ($fell(recfg_busy) |-> busy_cnt == BUSY_CYC)
      else $error("busy span wrong");
   a_step_four: assert property ($fell(phase_done) |-> !phase_done[*4] ##1 phase_done)
      else $error("step-complete low span wrong");
   a_arst_lock: assert property (ctrl_wr && avm_writedata[`PRC_CTRL_ARST] |-> ##2 !pll_locked[*4])
      else $error("lock kept under pll reset");
   a_lock_wait: assert property ($rose(pll_locked) |-> unlk_cnt >= LOCK_CYC - 1)
      else $error("lock returned too early");
   a_post_keeps_lock: assert property (ctrl_wr && avm_writedata[`PRC_CTRL_STEP] && phase_done
      && pll_locked && !avm_writedata[`PRC_CTRL_ARST] && avm_writedata[6:4] != `PRC_SEL_M
      |=> pll_locked[*6]) else $error("post phase step dropped lock");
   c_done: cover property (scan_done);
   c_step: cover property ($fell(phase_done));
   c_relock: cover property ($rose(pll_locked));
   c_irq: cover property (irq);
endmodule
bind prc_top prc_checker #(.LOCK_CYC(LOCK_CYC)) i_prc_checker (.clk, .sys_rst, .avm_address, .avm_read,
   .avm_write, .avm_writedata, .avm_readdata, .avm_waitrequest, .irq, .pll_locked, .scan_done,
   .recfg_busy, .phase_done);

// file: verif/prc_host.sv
// Purpose: user reconfiguration logic as an avalon-mm master
// Assumes: one wait state or more per access
// Notes:   requests held until waitrequest is seen low
`timescale 1ns/10ps
module prc_host (
   input wire clk,                    // clock
   output logic [7:0] avm_address,    // byte address
   output logic avm_read,             // read request
   output logic avm_write,            // write request
   output logic [31:0] avm_writedata, // write data
   input wire [31:0] avm_readdata,    // read data
   input wire avm_waitrequest,        // stall
   input wire pll_locked              // lock level
);
   // idle strobes from time zero; address and data matter only under a strobe
   initial begin
      avm_read = 1'b0;
      avm_write = 1'b0;
   end
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   task wr(input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      avm_address <= a;
      avm_writedata <= wd;
      avm_write <= 1'b1;
      do @(posedge clk); while (avm_waitrequest !== 1'b0);
      avm_write <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] rdata);
      @(posedge clk);
      avm_address <= a;
      avm_read <= 1'b1;
      do @(posedge clk); while (avm_waitrequest !== 1'b0);
      rdata = avm_readdata;
      avm_read <= 1'b0;
   endtask
   // wait up to 100 cycles for the lock level to reach lvl, lost or regained
   task wait_lock(input logic lvl);
      for (int i = 0; i < 100 && pll_locked !== lvl; i++) @(posedge clk);
   endtask
endmodule

// file: verif/tb.sv
// Purpose: self-checking bench for prc_top
// Assumes: short lock time so relock fits the run
// Notes:   bus traffic goes through the host model
`timescale 1ns/10ps
`include "prc_map.vh"
module tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   wire [7:0] avm_address;
   wire avm_read, avm_write, avm_waitrequest, irq, pll_locked, scan_done, recfg_busy, phase_done;
   wire [31:0] avm_writedata, avm_readdata;
   int mismatches = 0;
   int samples_checked = 0;
   int dones = 0;
   logic [31:0] d;
   // ----------------------------------------
   // clock, design, host
   // ----------------------------------------
   always #10 clk = ~clk;
   always @(posedge clk) if (scan_done === 1'b1) dones <= dones + 1;
   prc_top #(.LOCK_CYC(8)) i_prc_top (.clk, .sys_rst, .avm_address, .avm_read, .avm_write,
      .avm_writedata, .avm_readdata, .avm_waitrequest, .irq, .pll_locked, .scan_done, .recfg_busy,
      .phase_done);
   prc_host i_prc_host (.clk, .avm_address, .avm_read, .avm_write, .avm_writedata, .avm_readdata,
      .avm_waitrequest, .pll_locked);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      i_prc_host.rd(a, d);
      chk(d, exp);
   endtask
   task wait_done;
      for (int i = 0; i < 400 && scan_done !== 1'b1; i++) @(posedge clk);
   endtask
   // new step only once step-complete is back
   task step(input logic [2:0] sel, input logic dir);
      i_prc_host.wr(`PRC_OFS_CTRL, {25'h0, sel, dir, 3'b100});
      repeat (2) @(posedge clk);
      for (int i = 0; i < 20 && phase_done !== 1'b1; i++) @(posedge clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      i_prc_host.wait_lock(1'b1);
      rchk(`PRC_OFS_STATUS, 32'h0000_0005);
      rchk(`PRC_OFS_ALOOP, 32'h0001_0101);
      rchk(`PRC_OFS_APOST, 32'h0000_0001);
      rchk(`PRC_OFS_PHASE, 32'h0000_0000);
      rchk(8'h60, 32'h0000_0000);
      i_prc_host.wr(`PRC_OFS_CTRL, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(recfg_busy, 1'b0);
   endtask
   task t_loop;
      i_prc_host.wr(`PRC_OFS_SLOOP, 32'h0002_0304);
      i_prc_host.wr(`PRC_OFS_IMASK, 32'h0000_0001);
      i_prc_host.wr(`PRC_OFS_CTRL, 32'h0000_0001);
      i_prc_host.wr(`PRC_OFS_CTRL, 32'h0000_0001);
      i_prc_host.wr(`PRC_OFS_SLOOP, 32'h0000_0000);
      wait_done;
      i_prc_host.wait_lock(1'b0);
      chk(pll_locked, 1'b0);
      chk(irq, 1'b1);
      rchk(`PRC_OFS_SLOOP, 32'h0002_0304);
      rchk(`PRC_OFS_ALOOP, 32'h0002_0304);
      i_prc_host.wait_lock(1'b1);
      rchk(`PRC_OFS_ELOOP, 32'h0002_0304);
      chk(dones, 1);
      rchk(`PRC_OFS_ISTAT, 32'h0000_000D);
      i_prc_host.wr(`PRC_OFS_IMASK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      i_prc_host.wr(`PRC_OFS_IMASK, 32'h0000_0001);
      i_prc_host.wr(`PRC_OFS_ISTAT, 32'h0000_000F);
      rchk(`PRC_OFS_ISTAT, 32'h0000_0000);
      chk(irq, 1'b0);
   endtask
   task t_post;
      i_prc_host.wr(`PRC_OFS_SPOST, 32'h0000_0005);
      i_prc_host.wr(`PRC_OFS_CTRL, 32'h0000_0001);
      wait_done;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         chk(pll_locked, 1'b1);
      end
      rchk(`PRC_OFS_APOST, 32'h0000_0005);
      rchk(`PRC_OFS_APOST + 8'h04, 32'h0000_0000);
      chk(dones, 2);
      rchk(`PRC_OFS_ALOOP, 32'h0002_0304);
   endtask
   task t_phase;
      i_prc_host.wr(`PRC_OFS_CTRL, 32'h0000_0004);
      step(3'h0, 1'b0);
      rchk(`PRC_OFS_PHASE, 32'h0000_0001);
      step(3'h0, 1'b0);
      rchk(`PRC_OFS_PHASE, 32'h0000_0002);
      step(`PRC_SEL_ALL, 1'b1);
      rchk(`PRC_OFS_PHASE, 32'h0000_7FF9);
      step(`PRC_SEL_M, 1'b0);
      i_prc_host.wait_lock(1'b0);
      chk(pll_locked, 1'b0);
      rchk(`PRC_OFS_PHASE, 32'h0000_FFF9);
      i_prc_host.wait_lock(1'b1);
   endtask
   task t_arst;
      i_prc_host.wr(`PRC_OFS_CTRL, 32'h0000_0002);
      i_prc_host.wr(`PRC_OFS_CTRL, 32'h0000_0006);
      repeat (20) @(posedge clk);
      chk(pll_locked, 1'b0);
      chk(phase_done, 1'b1);
      rchk(`PRC_OFS_PHASE, 32'h0000_0000);
      rchk(`PRC_OFS_CTRL, 32'h0000_0052);
      i_prc_host.wr(`PRC_OFS_CTRL, 32'h0000_0000);
      i_prc_host.wait_lock(1'b1);
      chk(pll_locked, 1'b1);
   endtask
   task stop_test;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_loop;
      t_post;
      t_phase;
      t_arst;
      stop_test;
   end
   // generous: the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      stop_test;
   end
endmodule
